// >>> src/pbc_pkg.sv
// Package of constants and types for the PHY basic mode control block.
package pbc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] PBC_CTRL_OFS    = 12'h000;
	localparam logic [11:0] PBC_STAT_OFS    = 12'h004;
	localparam logic [11:0] PBC_NEG_OFS     = 12'h008;
	localparam logic [15:0] PBC_CTRL_RST    = 16'h3100;

	// ****************************************************************
	// Field positions of the control word
	// ****************************************************************
	localparam int PBC_B_RESET    = 15;
	localparam int PBC_B_LOOP     = 14;
	localparam int PBC_B_SPEED    = 13;
	localparam int PBC_B_AN_EN    = 12;
	localparam int PBC_B_PDOWN    = 11;
	localparam int PBC_B_ISOLATE  = 10;
	localparam int PBC_B_RESTART  = 9;
	localparam int PBC_B_DUPLEX   = 8;
	localparam int PBC_B_COLTEST  = 7;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int PBC_CLK_MHZ        = 100;
	localparam int PBC_DEAD_MS        = 720;
	localparam int PBC_DEAD_CYC       = PBC_DEAD_MS * 1000 * PBC_CLK_MHZ;
	localparam int PBC_RST_CYC        = 16;
	localparam int PBC_AN_START_CYC   = 4;

	// Negotiated result handed in by the link engine.
	typedef struct packed {
		logic speed_100;
		logic full_duplex;
	} pbc_neg_t;

	// Controls handed out to the PHY datapath.
	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic full_duplex;
		logic power_down;
		logic isolate;
		logic col_test;
		logic an_enable;
	} pbc_ctl_t;

endpackage

// >>> src/pbc_reset_seq.sv
// Internal reset sequencer started by the software reset bit.
`timescale 1ns/1ps
module pbc_reset_seq #(
	parameter int CYCLES = 16
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic start,
	output logic      busy
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	assign cnt_next = start ? W'(CYCLES) : (cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
	assign busy     = (cnt_reg != '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule // pbc_reset_seq

// >>> src/pbc_dead_timer.sv
// Receive dead-time timer after loopback entry at 100 Mbps.
`timescale 1ns/1ps
module pbc_dead_timer #(
	parameter int CYCLES = 72000000
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clear,
	input  wire logic start,
	output logic      active
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	assign cnt_next = clear ? '0 : start ? W'(CYCLES) :
		(cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
	assign active   = (cnt_reg != '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule // pbc_dead_timer

// >>> src/pbc_basic_control.sv
// APB register block for the PHY basic mode control word.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module pbc_basic_control #(
	parameter int DEAD_CYCLES = pbc_pkg::PBC_DEAD_CYC,
	parameter int RST_CYCLES  = pbc_pkg::PBC_RST_CYC
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire pbc_pkg::pbc_neg_t neg_result,
	input  wire logic              an_started,
	input  wire logic              tx_active,
	output pbc_pkg::pbc_ctl_t      phy_ctl,
	output logic                   an_kick,
	output logic                   col_out,
	output logic                   rx_block,
	output logic                   phy_soft_reset
);
	import pbc_pkg::*;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic        acc;
	logic        wr;
	logic        rd;
	logic        sel_ctrl;
	logic        sel_stat;
	logic        sel_neg;
	logic        mapped;
	logic [15:0] wdata;

	assign acc      = psel && penable;
	assign sel_ctrl = (paddr == PBC_CTRL_OFS);
	assign sel_stat = (paddr == PBC_STAT_OFS);
	assign sel_neg  = (paddr == PBC_NEG_OFS);
	assign mapped   = sel_ctrl || sel_stat || sel_neg;
	assign wr       = acc && pwrite && mapped;
	assign rd       = acc && !pwrite && mapped;
	assign pready   = 1'b1;
	// Register access never depends on power-down state.
	assign pslverr  = acc && !mapped;

	// Byte lane merge of the 16-bit control word.
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// ****************************************************************
	// Control word state
	// ****************************************************************
	logic        loop_reg;
	logic        speed_reg;
	logic        an_en_reg;
	logic        pdown_reg;
	logic        iso_reg;
	logic        restart_reg;
	logic        duplex_reg;
	logic        coltest_reg;
	logic        rst_busy;
	logic        rst_start;
	logic        soft_clr;
	logic        ctrl_wr;
	logic [15:0] cur_word;
	logic [15:0] new_word;
	logic        speed_eff;
	logic        duplex_eff;
	logic        restart_next;
	logic        loop_rise;

	assign ctrl_wr   = wr && sel_ctrl;
	assign new_word  = merge(cur_word, pwdata, pstrb);
	assign rst_start = ctrl_wr && new_word[PBC_B_RESET];
	assign soft_clr  = rst_start || rst_busy;

	// Negotiation enable routes the negotiated result out and back.
	assign speed_eff  = an_en_reg ? neg_result.speed_100 : speed_reg;
	assign duplex_eff = an_en_reg ? neg_result.full_duplex : duplex_reg;

	assign cur_word = {rst_busy, loop_reg, speed_eff, an_en_reg, pdown_reg, iso_reg,
		restart_reg, duplex_eff, coltest_reg, 7'h00};

	// Restart set only while negotiation enabled; cleared once started.
	// A write of zero drops the bit only; negotiation already kicked continues.
	assign restart_next = (ctrl_wr && new_word[PBC_B_RESTART] && new_word[PBC_B_AN_EN]) ? 1'b1 :
		an_started ? 1'b0 :
		ctrl_wr ? new_word[PBC_B_RESTART] & restart_reg : restart_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_reg    <= PBC_CTRL_RST[PBC_B_LOOP];
			speed_reg   <= PBC_CTRL_RST[PBC_B_SPEED];
			an_en_reg   <= PBC_CTRL_RST[PBC_B_AN_EN];
			pdown_reg   <= PBC_CTRL_RST[PBC_B_PDOWN];
			iso_reg     <= PBC_CTRL_RST[PBC_B_ISOLATE];
			restart_reg <= PBC_CTRL_RST[PBC_B_RESTART];
			duplex_reg  <= PBC_CTRL_RST[PBC_B_DUPLEX];
			coltest_reg <= PBC_CTRL_RST[PBC_B_COLTEST];
		end else if (soft_clr) begin
			loop_reg    <= PBC_CTRL_RST[PBC_B_LOOP];
			speed_reg   <= PBC_CTRL_RST[PBC_B_SPEED];
			an_en_reg   <= PBC_CTRL_RST[PBC_B_AN_EN];
			pdown_reg   <= PBC_CTRL_RST[PBC_B_PDOWN];
			iso_reg     <= PBC_CTRL_RST[PBC_B_ISOLATE];
			restart_reg <= PBC_CTRL_RST[PBC_B_RESTART];
			duplex_reg  <= PBC_CTRL_RST[PBC_B_DUPLEX];
			coltest_reg <= PBC_CTRL_RST[PBC_B_COLTEST];
		end else begin
			restart_reg <= restart_next;
			if (ctrl_wr) begin
				loop_reg    <= new_word[PBC_B_LOOP];
				speed_reg   <= new_word[PBC_B_SPEED];
				an_en_reg   <= new_word[PBC_B_AN_EN];
				pdown_reg   <= new_word[PBC_B_PDOWN];
				iso_reg     <= new_word[PBC_B_ISOLATE];
				coltest_reg <= new_word[PBC_B_COLTEST];
				if (!new_word[PBC_B_AN_EN]) begin
					duplex_reg <= new_word[PBC_B_DUPLEX];
				end
			end
		end
	end

	// ****************************************************************
	// Internal reset and dead time
	// ****************************************************************
	pbc_reset_seq #(.CYCLES(RST_CYCLES)) u_rst (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (rst_start),
		.busy    (rst_busy)
	);

	logic loop_d_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_d_reg <= 1'b0;
		end else begin
			loop_d_reg <= loop_reg;
		end
	end

	assign loop_rise = loop_reg && !loop_d_reg && speed_eff;

	pbc_dead_timer #(.CYCLES(DEAD_CYCLES)) u_dead (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (!loop_reg),
		.start   (loop_rise),
		.active  (rx_block)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	logic [31:0] rdata_next;
	logic        kick_reg;
	logic        col_reg;

	assign rdata_next = !rd ? 32'h0000_0000 :
		sel_ctrl ? {16'h0000, cur_word} :
		sel_stat ? {30'h0000_0000, rst_busy, restart_reg} :
		{30'h0000_0000, neg_result.speed_100, neg_result.full_duplex};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata   <= 32'h0000_0000;
			kick_reg <= 1'b0;
			col_reg  <= 1'b0;
		end else begin
			prdata   <= rdata_next;
			kick_reg <= restart_next && !restart_reg;
			col_reg  <= coltest_reg && tx_active;
		end
	end

	assign an_kick        = kick_reg;
	assign col_out        = col_reg;
	assign phy_soft_reset = rst_busy;
	assign phy_ctl        = '{loopback: loop_reg, speed_100: speed_eff,
		full_duplex: duplex_eff, power_down: pdown_reg, isolate: iso_reg,
		col_test: coltest_reg, an_enable: an_en_reg};

endmodule // pbc_basic_control

// >>> sim/pbc_basic_control_props.sv
// Concurrent checks on the ports of the basic mode control block.
`timescale 1ns/1ps
module pbc_basic_control_props
	import pbc_pkg::*;
#(
	parameter int RST_CYCLES = 16
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire pbc_neg_t    neg_result,
	input wire logic        tx_active,
	input wire pbc_ctl_t    phy_ctl,
	input wire logic        an_kick,
	input wire logic        col_out,
	input wire logic        phy_soft_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire rd0 = acc && !pwrite && paddr == PBC_CTRL_OFS;
	wire wr0 = acc && pwrite && paddr == PBC_CTRL_OFS;
	int busy_cnt;
	// Length of the current soft reset run.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) busy_cnt <= 0;
		else busy_cnt <= phy_soft_reset ? busy_cnt + 1 : 0;
	end
	chk_kick_pulse: assert property (an_kick |=> !an_kick)
		else $error("kick pulse too wide");
	chk_restart_kick: assert property (wr0 && pwdata[9] && pwdata[12] && !phy_soft_reset
		|-> ##[1:2] an_kick) else $error("restart did not kick");
	chk_col_follow: assert property (phy_ctl.col_test && tx_active |=> col_out)
		else $error("collision not shown");
	chk_col_quiet: assert property (!tx_active |=> !col_out)
		else $error("collision without transmit");
	chk_neg_mirror: assert property (phy_ctl.an_enable |-> phy_ctl.speed_100 ==
		neg_result.speed_100 && phy_ctl.full_duplex == neg_result.full_duplex)
		else $error("negotiated mode not used");
	chk_busy_len: assert property ($fell(phy_soft_reset) |-> busy_cnt == RST_CYCLES)
		else $error("soft reset length wrong");
	chk_busy_default: assert property (phy_soft_reset && $past(phy_soft_reset) |->
		!phy_ctl.loopback && !phy_ctl.power_down && phy_ctl.an_enable)
		else $error("fields not at default in reset");
	chk_reset_reads: assert property (rd0 && phy_soft_reset |=> prdata[15])
		else $error("reset bit read low while busy");
	chk_low_zero: assert property (rd0 |=> prdata[6:0] == 7'h00)
		else $error("reserved bits read nonzero");
	chk_pdown_ready: assert property (acc && phy_ctl.power_down |-> pready)
		else $error("no answer in power down");
	chk_unmapped: assert property (acc && paddr > PBC_NEG_OFS |-> pslverr)
		else $error("unmapped access not refused");
	cover property (rd0 && phy_soft_reset);
	cover property (an_kick);
	cover property (col_out);
endmodule // pbc_basic_control_props
bind pbc_basic_control pbc_basic_control_props #(.RST_CYCLES(RST_CYCLES)) u_props (.*);

// >>> sim/pbc_link_model.sv
// Model of the negotiation engine behind the control word.
`timescale 1ns/1ps
module pbc_link_model
	import pbc_pkg::*;
#(
	parameter int DELAY = 6
) (
	input  wire logic     pclk,
	input  wire logic     presetn,
	input  wire logic     an_kick,
	input  wire pbc_neg_t want,
	output pbc_neg_t      neg_result,
	output logic          an_started
);
	int cnt;
	// A kick starts negotiation after a delay; the result follows the bench.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			an_started <= 1'b0;
			neg_result <= '0;
		end else begin
			neg_result <= want;
			an_started <= cnt == 1;
			if (an_kick) cnt <= DELAY;
			else if (cnt != 0) cnt <= cnt - 1;
		end
	end
endmodule // pbc_link_model

// >>> sim/tb_phy_basic_mode_control.sv
// Self-checking bench of the basic mode control block.
`timescale 1ns/1ps
module tb_phy_basic_mode_control;
	import pbc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_active = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, an_kick, col_out, rx_block, phy_soft_reset, an_started;
	pbc_neg_t want = 2'b11, neg_result;
	pbc_ctl_t phy_ctl;
	int errors = 0, samples_checked = 0;
	always #5 pclk = ~pclk;
	pbc_basic_control #(.DEAD_CYCLES(50), .RST_CYCLES(4)) dut (.*);
	pbc_link_model link (.*);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		// Read data is registered at the access edge and stands for the next cycle.
		@(posedge pclk);
		r = prdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0000_0000, r);
		check(r, exp);
	endtask
	task automatic t_modes;
		rc(PBC_CTRL_OFS, 32'h0000_3100);
		want <= 2'b00;
		rc(PBC_CTRL_OFS, 32'h0000_1000);
		want <= 2'b11;
		wr(PBC_CTRL_OFS, 32'h0000_217F);
		rc(PBC_CTRL_OFS, 32'h0000_2100);
		wr(PBC_CTRL_OFS, 32'h0000_0000);
		rc(PBC_CTRL_OFS, 32'h0000_0000);
		wr(PBC_CTRL_OFS, 32'h0000_0800);
		rc(PBC_CTRL_OFS, 32'h0000_0800);
		rc(12'h00C, 32'h0000_0000);
	endtask
	task automatic t_loop;
		wr(PBC_CTRL_OFS, 32'h0000_6080);
		check(phy_ctl.loopback, 1);
		@(posedge pclk);
		check(rx_block, 1);
		tx_active <= 1;
		repeat (2) @(posedge pclk);
		check(col_out, 1);
		tx_active <= 0;
		repeat (60) @(posedge pclk);
		check(rx_block, 0);
		wr(PBC_CTRL_OFS, 32'h0000_2000);
		check(phy_ctl.loopback, 0);
	endtask
	task automatic t_restart;
		wr(PBC_CTRL_OFS, 32'h0000_1200);
		rc(PBC_CTRL_OFS, 32'h0000_3300);
		repeat (10) @(posedge pclk);
		rc(PBC_CTRL_OFS, 32'h0000_3100);
	endtask
	task automatic t_soft;
		wr(PBC_CTRL_OFS, 32'h0000_4880);
		wr(PBC_CTRL_OFS, 32'h0000_8000);
		rc(PBC_CTRL_OFS, 32'h0000_B100);
		for (int i = 0; i < 50 && phy_soft_reset !== 1'b0; i++) @(posedge pclk);
		rc(PBC_CTRL_OFS, 32'h0000_3100);
	endtask
	task automatic print_verdict;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		t_modes();
		t_loop();
		t_restart();
		t_soft();
		print_verdict();
	end
	initial begin
		#50000;
		errors++;
		print_verdict();
	end
endmodule // tb_phy_basic_mode_control
